// ---- adc_seq_pkg.sv ----
// Register map, field layout and helper functions of the converter sequencer
package adc_seq_pkg;

   // ***************************************
   // Register word indices (byte = 4 x index)
   // ***************************************
   localparam logic [2:0] REG_CTRL   = 3'h0;
   localparam logic [2:0] REG_REFPIN = 3'h1;
   localparam logic [2:0] REG_FMT    = 3'h2;
   localparam logic [2:0] REG_RESH   = 3'h3;
   localparam logic [2:0] REG_RESL   = 3'h4;
   localparam logic [2:0] REG_FLAG   = 3'h5;

   // ***************************************
   // Field positions and masks
   // ***************************************
   localparam int         ON_BIT      = 0;
   localparam int         GO_BIT      = 1;
   localparam int         CHAN_LSB    = 2;
   localparam int         POS_REF_BIT = 4;
   localparam int         NEG_REF_BIT = 5;
   localparam int         PCFG_LSB    = 0;
   localparam int         JUSTIFY_BIT = 7;
   localparam int         ACQ_LSB     = 3;
   localparam int         CS_LSB      = 0;
   localparam int         FLAG_BIT    = 0;
   localparam int         IE_BIT      = 1;
   localparam logic [7:0] REFPIN_MASK = 8'h3F;
   localparam logic [7:0] FMT_MASK    = 8'hBF;
   localparam logic [7:0] RESET_VAL   = 8'h00;
   localparam logic [1:0] RC_CODE     = 2'h3;

   // ***************************************
   // Timing counts
   // ***************************************
   localparam int         CONV_TADS   = 11;
   localparam int         GAP_TADS    = 2;
   localparam int         TCY_MCLK    = 4;

   typedef enum logic [2:0] {SEQ_IDLE, SEQ_WAKE, SEQ_ACQ, SEQ_CONV, SEQ_GAP} seq_e;

   function automatic logic [4:0] acq_tads(input logic [2:0] s);
      case (s)
         3'h0: acq_tads = 5'h00;
         3'h1: acq_tads = 5'h02;
         3'h2: acq_tads = 5'h04;
         3'h3: acq_tads = 5'h06;
         3'h4: acq_tads = 5'h08;
         3'h5: acq_tads = 5'h0C;
         3'h6: acq_tads = 5'h10;
         default: acq_tads = 5'h14;
      endcase
   endfunction

   // Oscillator periods per conversion clock; RC codes unused here
   function automatic logic [6:0] clk_div(input logic [2:0] s);
      case (s)
         3'h0: clk_div = 7'h02;
         3'h1: clk_div = 7'h08;
         3'h2: clk_div = 7'h20;
         3'h4: clk_div = 7'h04;
         3'h5: clk_div = 7'h10;
         3'h6: clk_div = 7'h40;
         default: clk_div = 7'h02;
      endcase
   endfunction

   function automatic logic [15:0] digital_mask(input logic [3:0] k);
      logic [15:0] m;
      m = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         m[i] = (k != 4'h0) && (i + int'(k) >= 15);
      end
      return m;
   endfunction

   function automatic logic [15:0] justify(input logic [9:0] r, input logic right);
      return right ? {6'h00, r} : {r, 6'h00};
   endfunction

endpackage

// ---- adc_config_and_sequencer.sv ----
// Converter configuration registers, conversion clock and conversion sequencer
// Overview of operation
// - Negative reference: pin or analog ground
// - Positive reference: pin or analog supply
// - Pin config code sets digital top pins
// - Format bit picks right or left justify
// - Acquisition field selects 0..20 clock periods
// - Clock field picks divider or RC
// - RC clock starts one instruction cycle late
// - Completion loads result, clears status, sets flag
// - Reset clears registers and aborts conversion
// - Power-on reset leaves result untouched
// - Sleep conversion only with RC clock
// - Two clock periods idle after conversion
// - Programmed acquisition precedes conversion start
// - Holding capacitor disconnected during conversion
// - Status bit shows conversion in progress
// - Clearing status aborts, result kept
// - Conversion lasts eleven clock periods
// - Sampling resumes after conversion ends
//
// Chosen here: the register addresses and the Avalon-MM register port.
module adc_config_and_sequencer
   import adc_seq_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   input  wire logic [2:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        sleep_i,
   input  wire logic        rc_clk_i,
   input  wire logic        cmp_i,
   output logic             pos_ref_ext_o,
   output logic             neg_ref_ext_o,
   output logic      [15:0] pin_digital_o,
   output logic      [3:0]  channel_o,
   output logic             sample_connect_o,
   output logic      [9:0]  dac_code_o,
   output logic             conv_done_flag_o,
   output logic             conv_done_irq_enable_o
);

   // ***************************************
   // State
   // ***************************************
   typedef struct packed {
      logic       ack;
      logic [7:0] rdata;
      logic       on;
      logic       go;
      logic [3:0] chan;
      logic [7:0] refpin;
      logic [7:0] fmt;
      logic       flag;
      logic       ie;
      seq_e       st;
      logic [6:0] div;
      logic [4:0] conv_clock_period;
      logic [3:0] bidx;
      logic [9:0] sar;
      logic [4:0] hcnt;
      logic       rc1;
      logic       rc2;
      logic       rc3;
      logic       cmp1;
   } state_s;

   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } result_s;

   state_s  q;
   state_s  d;
   result_s res_q;
   result_s res_d;
   logic    req_c;
   logic    wr_c;
   logic    rc_sel_c;
   logic    tick_c;
   logic    done_c;
   logic    abort_c;
   logic [4:0]  acq_c;
   logic [6:0]  ratio_c;
   logic [15:0] just_c;

   // ***************************************
   // Next state
   // ***************************************
   always_comb begin
      d        = q;
      res_d    = res_q;
      done_c   = 1'b0;
      abort_c  = 1'b0;
      req_c    = avs_read_i | avs_write_i;
      wr_c     = avs_write_i & q.ack & avs_byteenable_i[0];
      acq_c    = acq_tads(q.fmt[ACQ_LSB+:3]);
      ratio_c  = clk_div(q.fmt[CS_LSB+:3]);
      rc_sel_c = q.fmt[CS_LSB+:2] == RC_CODE;

      // RC clock is asynchronous; its edge is taken from the second and third stages
      d.rc1  = rc_clk_i;
      d.rc2  = q.rc1;
      d.rc3  = q.rc2;
      // Comparator is strobed by this clock; a single register stage fits within a /2 period
      d.cmp1 = cmp_i;

      // Oscillator divider halts in sleep, so only RC can convert there
      tick_c = rc_sel_c ? (q.rc2 & ~q.rc3)
                        : (~sleep_i && (q.div == ratio_c - 7'h01));
      if (q.st == SEQ_IDLE || rc_sel_c || tick_c) begin
         d.div = 7'h00;
      end else if (!sleep_i) begin
         d.div = q.div + 7'h01;
      end

      // Bus: one wait cycle, read data captured on the first cycle
      d.ack = req_c & ~q.ack;
      unique case (avs_address_i)
         REG_CTRL:   d.rdata = {2'h0, q.chan, q.go, q.on};
         REG_REFPIN: d.rdata = q.refpin & REFPIN_MASK;
         REG_FMT:    d.rdata = q.fmt & FMT_MASK;
         REG_RESH:   d.rdata = res_q.hi;
         REG_RESL:   d.rdata = res_q.lo;
         REG_FLAG:   d.rdata = {6'h00, q.ie, q.flag};
         default:    d.rdata = RESET_VAL;
      endcase
      if (wr_c) begin
         unique case (avs_address_i)
            REG_CTRL: begin
               d.on   = avs_writedata_i[ON_BIT];
               d.go   = avs_writedata_i[GO_BIT];
               d.chan = avs_writedata_i[CHAN_LSB+:4];
            end
            REG_REFPIN: d.refpin = avs_writedata_i[7:0] & REFPIN_MASK;
            REG_FMT:    d.fmt = avs_writedata_i[7:0] & FMT_MASK;
            REG_RESH:   res_d.hi = avs_writedata_i[7:0];
            REG_RESL:   res_d.lo = avs_writedata_i[7:0];
            REG_FLAG: begin
               d.flag = avs_writedata_i[FLAG_BIT];
               d.ie   = avs_writedata_i[IE_BIT];
            end
            default: ;
         endcase
      end

      // Sequencer
      just_c = justify(q.sar, q.fmt[JUSTIFY_BIT]);
      unique case (q.st)
         SEQ_IDLE: begin
            if (q.on && q.go) begin
               d.conv_clock_period  = 5'h00;
               d.bidx = 4'h0;
               d.sar  = 10'h000;
               if (rc_sel_c) begin
                  d.st = SEQ_WAKE;
               end else if (acq_c != 5'h00) begin
                  d.st = SEQ_ACQ;
               end else begin
                  d.st = SEQ_CONV;
               end
            end
         end
         SEQ_WAKE: begin
            d.conv_clock_period = q.conv_clock_period + 5'h01;
            if (q.conv_clock_period == 5'(TCY_MCLK - 1)) begin
               d.conv_clock_period = 5'h00;
               d.st  = (acq_c != 5'h00) ? SEQ_ACQ : SEQ_CONV;
            end
         end
         SEQ_ACQ: begin
            if (tick_c) begin
               d.conv_clock_period = q.conv_clock_period + 5'h01;
               if (q.conv_clock_period == acq_c - 5'h01) begin
                  d.st = SEQ_CONV;
               end
            end
         end
         SEQ_CONV: begin
            if (tick_c) begin
               d.bidx = q.bidx + 4'h1;
               if (q.bidx < 4'hA && q.cmp1) begin
                  d.sar = q.sar | (10'h200 >> q.bidx);
               end
               if (q.bidx == 4'(CONV_TADS - 1)) begin
                  done_c   = 1'b1;
                  res_d.hi = just_c[15:8];
                  res_d.lo = just_c[7:0];
                  d.conv_clock_period    = 5'h00;
                  d.st     = SEQ_GAP;
               end
            end
         end
         SEQ_GAP: begin
            if (tick_c) begin
               d.conv_clock_period = q.conv_clock_period + 5'h01;
               if (q.conv_clock_period == 5'(GAP_TADS - 1)) begin
                  d.st = SEQ_IDLE;
               end
            end
         end
         default: d.st = SEQ_IDLE;
      endcase

      // Software clear of status aborts without touching the result
      if ((q.st == SEQ_ACQ || q.st == SEQ_CONV || q.st == SEQ_WAKE) && !q.go) begin
         abort_c  = 1'b1;
         done_c   = 1'b0;
         res_d    = res_q;
         d.conv_clock_period    = 5'h00;
         d.st     = SEQ_GAP;
      end
      if (!q.on) begin
         d.st = SEQ_IDLE;
      end
      if (done_c) begin
         d.go   = 1'b0;
         d.flag = 1'b1;
      end

      // Helper: conversion clock periods spent in the current state
      if (d.st != q.st) begin
         d.hcnt = 5'h00;
      end else if (tick_c) begin
         d.hcnt = q.hcnt + 5'h01;
      end
   end

   // ***************************************
   // Registers
   // ***************************************
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Result pair has no reset so power-up leaves it as found
   always_ff @(posedge mclk_i) begin
      res_q <= res_d;
   end

   // ***************************************
   // Outputs
   // ***************************************
   assign avs_waitrequest_o      = req_c & ~q.ack;
   assign avs_readdata_o         = {24'h000000, q.rdata};
   assign pos_ref_ext_o          = q.refpin[POS_REF_BIT];
   assign neg_ref_ext_o          = q.refpin[NEG_REF_BIT];
   assign pin_digital_o          = digital_mask(q.refpin[PCFG_LSB+:4]);
   assign channel_o              = q.chan;
   assign sample_connect_o       = q.on && (q.st != SEQ_CONV) && (q.st != SEQ_GAP);
   assign dac_code_o             = (q.st == SEQ_CONV && q.bidx < 4'hA) ?
                                   (q.sar | (10'h200 >> q.bidx)) : q.sar;
   assign conv_done_flag_o       = q.flag;
   assign conv_done_irq_enable_o = q.ie;

   // ***************************************
   // Assertions
   // ***************************************
   a_done_status: assert property (@(posedge mclk_i) disable iff (rst_i)
      done_c |=> !q.go && q.flag && (q.st == SEQ_GAP))
      else $error("completion did not clear status and set flag");

   a_result_load: assert property (@(posedge mclk_i) disable iff (rst_i)
      done_c |=> {res_q.hi, res_q.lo} == justify($past(q.sar), $past(q.fmt[JUSTIFY_BIT])))
      else $error("result not loaded in selected format");

   a_pin_count: assert property (@(posedge mclk_i) disable iff (rst_i)
      $countones(pin_digital_o) ==
      ((q.refpin[3:0] == 4'h0) ? 0 : int'(q.refpin[3:0]) + 1))
      else $error("digital pin count wrong");

   a_hold_open: assert property (@(posedge mclk_i) disable iff (rst_i)
      (q.st == SEQ_CONV) |-> !sample_connect_o)
      else $error("holding capacitor connected during conversion");

   a_gap_min: assert property (@(posedge mclk_i) disable iff (rst_i)
      (done_c || abort_c) |=> (q.st == SEQ_GAP || !q.on)[*4])
      else $error("idle gap too short");

   a_conv_len: assert property (@(posedge mclk_i) disable iff (rst_i)
      done_c |-> q.hcnt == 5'(CONV_TADS - 1))
      else $error("conversion length not eleven periods");

   a_acq_len: assert property (@(posedge mclk_i) disable iff (rst_i)
      (q.st == SEQ_ACQ && d.st == SEQ_CONV) |-> q.hcnt + 5'h01 == acq_c)
      else $error("acquisition length mismatch");

   a_abort_keep: assert property (@(posedge mclk_i) disable iff (rst_i)
      abort_c && !wr_c |=> $stable(res_q) && (q.st == SEQ_GAP || q.st == SEQ_IDLE))
      else $error("abort changed result");

   a_off_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
      !q.on |-> !sample_connect_o ##1 q.st == SEQ_IDLE)
      else $error("converter off but sequencer active");

   a_rc_delay: assert property (@(posedge mclk_i) disable iff (rst_i)
      $rose(q.st == SEQ_WAKE) |-> (q.st == SEQ_WAKE || !q.go || !q.on)[*4])
      else $error("RC start delay too short");

   a_ref_update: assert property (@(posedge mclk_i) disable iff (rst_i)
      (wr_c && avs_address_i == REG_REFPIN) |=>
      (neg_ref_ext_o == $past(avs_writedata_i[NEG_REF_BIT])) &&
      (pos_ref_ext_o == $past(avs_writedata_i[POS_REF_BIT])))
      else $error("reference select not taken from write");

   a_spare_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
      (avs_read_i && !avs_waitrequest_o) |->
      !(avs_address_i == REG_REFPIN && avs_readdata_o[7:6] != 2'h0) &&
      !(avs_address_i == REG_FMT && avs_readdata_o[6]))
      else $error("unimplemented bit read as one");

   a_resume_sampling: assert property (@(posedge mclk_i) disable iff (rst_i)
      (q.st == SEQ_GAP && d.st == SEQ_IDLE && q.on) |=> sample_connect_o || !q.on)
      else $error("sampling did not resume after gap");

   a_bus_wait: assert property (@(posedge mclk_i) disable iff (rst_i)
      (req_c && !q.ack) |=> !avs_waitrequest_o)
      else $error("bus answer not after one wait cycle");

   a_flag_set: assert property (@(posedge mclk_i) disable iff (rst_i)
      $rose(q.flag) |-> $past(done_c) || $past(wr_c && avs_address_i == REG_FLAG))
      else $error("done flag set without completion or write");

   c_full_conv: cover property (@(posedge mclk_i) disable iff (rst_i)
      (q.st == SEQ_ACQ) ##[1:1000] done_c);
   c_abort: cover property (@(posedge mclk_i) disable iff (rst_i)
      (q.st == SEQ_CONV) && abort_c);
   c_rc_conv: cover property (@(posedge mclk_i) disable iff (rst_i)
      rc_sel_c && done_c);
   c_left_result: cover property (@(posedge mclk_i) disable iff (rst_i)
      done_c && !q.fmt[JUSTIFY_BIT]);
   c_rc_sleep: cover property (@(posedge mclk_i) disable iff (rst_i)
      sleep_i && rc_sel_c && done_c);

endmodule

// ---- adc_sample_hold_model.sv ----
// Behavioural sample-and-hold, comparator and internal RC oscillator
module adc_sample_hold_model (
   input  wire logic       mclk_i,
   input  wire logic [3:0] channel_i,
   input  wire logic       sample_connect_i,
   input  wire logic [9:0] dac_code_i,
   output logic            cmp_o,
   output logic            rc_clk_o
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [9:0] held_q;
   logic       noise_q = 1'b0;
   logic       rc_q    = 1'b0;

   // *****************
   // Oscillator
   // *****************
   // Free running, unrelated in phase to the system clock
   always #23.5 rc_q = ~rc_q;
   assign rc_clk_o = rc_q;

   // *****************
   // Hold and compare
   // *****************
   // Level per channel, so a wrong channel shows in the result
   always @(posedge mclk_i) begin
      if (sample_connect_i) begin
         held_q <= {channel_i, 6'h2D};
      end
      noise_q <= ~noise_q;
   end
   // Comparator is meaningless while tracking: toggle, never a stable guess
   assign cmp_o = sample_connect_i ? noise_q : (held_q >= dac_code_i);
endmodule

// ---- tb_top.sv ----
// Self-checking testbench of the converter configuration and sequencer
module tb_top
   import adc_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic        mclk = 1'b0;
   logic        rst  = 1'b1;
   logic        rd   = 1'b0;
   logic        wr   = 1'b0;
   logic        sleep = 1'b0;
   logic [2:0]  addr = 3'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  be   = 4'h1;
   logic [31:0] rdata;
   logic        waitreq, rc_clk, cmp, pos_ref, neg_ref, samp, flag, ie;
   logic [15:0] pin_dig;
   logic [3:0]  chan;
   logic [9:0]  dac;
   int          mismatches = 0;
   int          n_compared = 0;

   always #2.5 mclk = ~mclk;

   adc_config_and_sequencer adc_config_and_sequencer_i (
      .mclk_i(mclk), .rst_i(rst), .avs_address_i(addr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
      .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .sleep_i(sleep),
      .rc_clk_i(rc_clk), .cmp_i(cmp), .pos_ref_ext_o(pos_ref), .neg_ref_ext_o(neg_ref),
      .pin_digital_o(pin_dig), .channel_o(chan), .sample_connect_o(samp),
      .dac_code_o(dac), .conv_done_flag_o(flag), .conv_done_irq_enable_o(ie));

   adc_sample_hold_model adc_sample_hold_model_i (
      .mclk_i(mclk), .channel_i(chan), .sample_connect_i(samp),
      .dac_code_i(dac), .cmp_o(cmp), .rc_clk_o(rc_clk));

   // ***************************************
   // Checking and bus tasks
   // ***************************************
   task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask

   // Waitrequest is combinational: look at it mid-cycle, act on the next rise
   task automatic bus(input logic [2:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] q);
      logic busy;
      @(posedge mclk);
      addr  <= a;
      wdata <= {24'h000000, d};
      rd    <= ~w;
      wr    <= w;
      do begin
         @(negedge mclk);
         busy = waitreq;
         q = rdata[7:0];
         @(posedge mclk);
      end while (busy !== 1'b0);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(a, 1'b1, d, q);
   endtask

   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string what);
      logic [7:0] q;
      bus(a, 1'b0, 8'h00, q);
      chk_val(what, {8'h00, exp}, {8'h00, q});
   endtask

   task automatic wait_samp(input logic lvl, output int n);
      n = 0;
      @(negedge mclk);
      while (samp !== lvl) begin
         @(negedge mclk);
         n++;
      end
   endtask

   function automatic logic near(input int a, input int e);
      return (a >= e - 2) && (a <= e + 2);
   endfunction

   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ***************************************
   // Tests
   // ***************************************
   initial begin
      int         cs_tab[8];
      int         acq_tab[8];
      int         div_tab[8];
      int         n, m;
      logic [3:0] k, ch;
      logic [2:0] cs;
      logic [9:0] r;
      logic [15:0] msk;
      cs_tab  = '{0, 1, 2, 4, 5, 6, 3, 7};
      acq_tab = '{0, 2, 4, 6, 8, 12, 16, 20};
      div_tab = '{2, 8, 32, 4, 16, 64, 0, 0};
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      rd_chk(REG_CTRL, 8'h00, "ctrl reset");
      rd_chk(REG_REFPIN, 8'h00, "refpin reset");
      rd_chk(REG_FMT, 8'h00, "fmt reset");
      wr_reg(3'h6, 8'h5A);
      rd_chk(3'h6, 8'h00, "unmapped");
      $display("test reset values done");
      wr_reg(REG_REFPIN, 8'hFF);
      rd_chk(REG_REFPIN, 8'h3F, "refpin spare bits");
      be <= 4'h0;
      wr_reg(REG_REFPIN, 8'h00);
      be <= 4'h1;
      rd_chk(REG_REFPIN, 8'h3F, "byte disabled write");
      for (int j = 0; j < 16; j++) begin
         k = 4'(j);
         wr_reg(REG_REFPIN, {2'b00, k[0], k[1], k});
         @(negedge mclk);
         for (int i = 0; i < 16; i++) msk[i] = (k != 4'h0) && (i >= 15 - j);
         chk_val("pin digital", msk, pin_dig);
         chk_bit("neg ref", k[0], neg_ref);
         chk_bit("pos ref", k[1], pos_ref);
      end
      wr_reg(REG_FMT, 8'hFF);
      rd_chk(REG_FMT, 8'hBF, "fmt spare bit");
      wr_reg(REG_FLAG, 8'h02);
      @(negedge mclk);
      chk_bit("irq enable", 1'b1, ie);
      $display("test config done");
      // Every acquisition code, every clock code, both formats
      for (int i = 0; i < 8; i++) begin
         ch = 4'(2 * i + 1);
         cs = 3'(cs_tab[i]);
         r  = {ch, 6'h2D};
         wr_reg(REG_FMT, {i[0], 1'b0, 3'(i), cs});
         wr_reg(REG_CTRL, {2'b00, ch, 2'b01});
         sleep <= (cs[1:0] == 2'b11);
         wr_reg(REG_CTRL, {2'b00, ch, 2'b11});
         wait_samp(1'b0, n);
         wait_samp(1'b1, m);
         if (cs[1:0] != 2'b11) begin
            chk_bit("acquisition span", 1'b1, near(n, acq_tab[i] * div_tab[i]));
            chk_bit("convert and gap span", 1'b1, near(m, 13 * div_tab[i]));
         end
         sleep <= 1'b0;
         rd_chk(REG_CTRL, {2'b00, ch, 2'b01}, "status after done");
         rd_chk(REG_FLAG, 8'h03, "done flag");
         rd_chk(REG_RESH, i[0] ? {6'h00, r[9:8]} : r[9:2], "result high");
         rd_chk(REG_RESL, i[0] ? r[7:0] : {r[1:0], 6'h00}, "result low");
         chk_bit("sampling resumed", 1'b1, samp);
         chk_bit("done flag pin", 1'b1, flag);
         chk_val("channel out", {12'h000, ch}, {12'h000, chan});
         wr_reg(REG_FLAG, 8'h02);
         $display("test conversion %0d done", i);
      end
      // Abort in mid conversion keeps the last result
      wr_reg(REG_FMT, 8'h06);
      wr_reg(REG_CTRL, 8'h07);
      rd_chk(REG_CTRL, 8'h07, "status busy");
      wr_reg(REG_CTRL, 8'h05);
      wait_samp(1'b1, m);
      rd_chk(REG_RESH, 8'h03, "abort result high");
      rd_chk(REG_RESL, 8'hED, "abort result low");
      rd_chk(REG_FLAG, 8'h02, "abort no flag");
      $display("test abort done");
      // Reset in mid conversion
      wr_reg(REG_CTRL, 8'h07);
      repeat (20) @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      chk_bit("sampler off", 1'b0, samp);
      rd_chk(REG_CTRL, 8'h00, "ctrl after reset");
      rd_chk(REG_FMT, 8'h00, "fmt after reset");
      rd_chk(REG_RESH, 8'h03, "result high kept");
      rd_chk(REG_RESL, 8'hED, "result low kept");
      $display("test reset abort done");
      stop_test;
   end

   // Whole sequence needs well under ten thousand cycles
   initial begin
      repeat (40000) @(posedge mclk);
      mismatches++;
      $display("[ERR] run time expected finish seen hang");
      stop_test;
   end
endmodule
